// ### logic/adc_ctrl.v
// host-side controller for a parallel-readout sampling converter
// assumes the converter pins are synchronous to i_clk; status from the
// converter arrives on i_busy, data on the three-state output bus
// Functional notes
// (R1) status high while converting, low otherwise
// (R2) chip select fall starts acquisition
// (R3) trigger fall ends acquisition, starts conversion
// (R4) width 0: all eighteen bits, one read
// (R5) width 1, byte 0: low bits on 9..2; the code reads them on 3..2
// (R6) width 1, byte 1: low bits on 17..10; the code reads them on 11..10
// (R7) byte 1 folds bits 9..2 to 17..10
// (R8) 50 ns from last read to trigger
// (R9) read only after status falls
// (R10) top bits valid when status falls
// (R11) bus released within 30 ns of strobe
// (R12) chip select steady 50 ns around status fall
// (R13) select transitions spaced 50 ns
// (R14) abort edge 70 to 480 ns after trigger
// (R15) data valid within 30 ns of strobe
// (R16) aborted conversion yields no new result
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_ctrl (
    input wire i_clk, // 40 MHz system clock
    input wire i_nrst, // async reset, active low
    input wire [1:0] i_addr, // register index
    input wire [7:0] i_wdata, // write data
    input wire i_wr, // write strobe
    input wire i_rd, // read strobe
    output reg [31:0] o_rdata, // read data, cycle after i_rd
    output reg o_cs_n, // converter chip select, active low
    output reg o_conversion_trigger_n, // converter trigger, active low
    output reg o_rd_n, // converter read strobe, active low
    output reg o_byte_select, // fold select to converter
    output reg o_width_select, // 18/16 select to converter
    input wire i_busy, // converter status, high while converting
    input wire [17:0] i_output_bus // converter data bus
);
    // states
    localparam S_IDLE = 4'h0;
    localparam S_ACQ = 4'h1;
    localparam S_TRIG = 4'h2;
    localparam S_CONV = 4'h3;
    localparam S_SEL = 4'h4;
    localparam S_RDLO = 4'h5;
    localparam S_GAP = 4'h6;
    localparam S_PUSH = 4'h7;
    localparam S_ABORT = 4'h8;
    localparam S_CSHOLD = 4'h9;
    // cycle counts, cut to the timer width where they are loaded
    localparam [31:0] ACQ_LD = `ACQ_CYC;
    localparam [31:0] TRIG_LD = `TRIG_LOW_CYC;
    localparam [31:0] SEL_LD = `SEL_SPACE_CYC;
    localparam [31:0] RDLO_LD = `RD_LOW_CYC;
    localparam [31:0] HOLD_LD = `RD_TO_TRIG_CYC;

    reg [3:0] state_reg; // sequencer state
    reg [`CNT_W-1:0] cnt_reg; // phase timer
    reg [`CNT_W-1:0] conv_cnt_reg; // cycles since trigger fall
    reg [1:0] mode_reg; // read width mode
    reg [1:0] part_reg; // which read of the word
    reg [`RES_W-1:0] acc_reg; // assembled result
    reg abort_req_reg; // abort requested by software
    reg busy_d_reg; // status one cycle ago
    reg aborted_reg; // last conversion was aborted
    reg overflow_reg; // result dropped, fifo full
    wire busy_fall;
    wire fifo_ready;
    wire fifo_valid;
    wire [`RES_W-1:0] fifo_data;
    wire fifo_pop;
    wire last_part;

    ////////////////////////////////////////////////////////////////////
    // result fifo, drained by software data reads
    assign fifo_pop = i_rd && (i_addr == `REG_DATA);
    adc_fifo #(
        .WIDTH(`RES_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) adc_fifo_i (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_in_valid(state_reg == S_PUSH),
        .o_in_ready(fifo_ready),
        .i_in_data(acc_reg),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    // status edge detect; conversion is running while i_busy is high
    assign busy_fall = busy_d_reg && !i_busy; // [R1]
    assign last_part = (mode_reg == `MODE_18) ||
        (mode_reg == `MODE_16 && part_reg == 2'h1) ||
        (mode_reg == `MODE_8 && part_reg == 2'h2);

    ////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after strobe
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            case (i_addr)
                `REG_CTRL: o_rdata <= {28'h0, mode_reg, 2'h0};
                `REG_STAT: o_rdata <= {24'h0, fifo_valid, overflow_reg,
                    aborted_reg, i_busy, state_reg};
                `REG_DATA: o_rdata <= {fifo_valid, 13'h0, fifo_data};
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer driving the converter pins
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= S_IDLE;
            cnt_reg <= {`CNT_W{1'b0}};
            conv_cnt_reg <= {`CNT_W{1'b0}};
            mode_reg <= `MODE_18;
            part_reg <= 2'h0;
            acc_reg <= {`RES_W{1'b0}};
            abort_req_reg <= 1'b0;
            busy_d_reg <= 1'b0;
            aborted_reg <= 1'b0;
            overflow_reg <= 1'b0;
            o_cs_n <= 1'b1;
            o_conversion_trigger_n <= 1'b1;
            o_rd_n <= 1'b1;
            o_byte_select <= 1'b0;
            o_width_select <= 1'b0;
        end else begin
            busy_d_reg <= i_busy;
            if (cnt_reg != {`CNT_W{1'b0}}) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            if (conv_cnt_reg != {`CNT_W{1'b1}}) begin
                conv_cnt_reg <= conv_cnt_reg + 1'b1;
            end
            // abort request latches until used or the conversion ends; idle clears it
            if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_ABORT]) begin
                abort_req_reg <= 1'b1;
            end
            // software clear first, so a drop in the same cycle still sets
            if (i_wr && i_addr == `REG_STAT) begin
                overflow_reg <= 1'b0;
            end
            case (state_reg)
                S_IDLE: begin
                    abort_req_reg <= 1'b0;
                    if (i_wr && i_addr == `REG_CTRL &&
                        i_wdata[`CTRL_START]) begin
                        mode_reg <= i_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
                        o_cs_n <= 1'b0; // [R2]
                        cnt_reg <= ACQ_LD[`CNT_W-1:0];
                        state_reg <= S_ACQ;
                    end
                end
                S_ACQ: begin
                    // acquisition runs from chip select fall
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        o_conversion_trigger_n <= 1'b0; // [R3]
                        conv_cnt_reg <= {`CNT_W{1'b0}};
                        cnt_reg <= TRIG_LD[`CNT_W-1:0];
                        aborted_reg <= 1'b0;
                        state_reg <= S_TRIG;
                    end
                end
                S_TRIG: begin
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        o_conversion_trigger_n <= 1'b1;
                        state_reg <= S_CONV;
                    end
                end
                S_CONV: begin
                    // abort only inside its legal window
                    if (abort_req_reg &&
                        conv_cnt_reg >= `ABORT_MIN_CYC - 1 &&
                        conv_cnt_reg < `ABORT_MAX_CYC) begin // [R14]
                        o_conversion_trigger_n <= 1'b0;
                        abort_req_reg <= 1'b0;
                        aborted_reg <= 1'b1;
                        cnt_reg <= TRIG_LD[`CNT_W-1:0];
                        state_reg <= S_ABORT;
                    end else if (busy_fall) begin
                        // bus valid at status fall, reads may start [R9]
                        abort_req_reg <= 1'b0;
                        part_reg <= 2'h0;
                        // first read of every width is unfolded
                        o_width_select <= 1'b0; // [R4]
                        o_byte_select <= 1'b0; // [R7]
                        cnt_reg <= SEL_LD[`CNT_W-1:0]; // [R13]
                        state_reg <= S_SEL;
                    end
                end
                S_ABORT: begin
                    // no new result; release chip select and return to idle [R16]
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        o_conversion_trigger_n <= 1'b1;
                        cnt_reg <= HOLD_LD[`CNT_W-1:0];
                        state_reg <= S_CSHOLD;
                    end
                end
                S_SEL: begin
                    // selects settle before strobe falls
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        o_rd_n <= 1'b0; // [R15]
                        cnt_reg <= RDLO_LD[`CNT_W-1:0];
                        state_reg <= S_RDLO;
                    end
                end
                S_RDLO: begin
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        // sample bus before releasing strobe [R10]
                        case (mode_reg)
                            `MODE_16: begin
                                if (part_reg == 2'h0) begin
                                    acc_reg[17:2] <= i_output_bus[17:2];
                                end else begin
                                    acc_reg[1:0] <= i_output_bus[3:2];
                                end
                            end
                            `MODE_8: begin
                                if (part_reg == 2'h0) begin
                                    acc_reg[17:10] <= i_output_bus[17:10];
                                end else if (part_reg == 2'h1) begin
                                    acc_reg[9:2] <= i_output_bus[17:10];
                                end else begin
                                    acc_reg[1:0] <= i_output_bus[11:10];
                                end
                            end
                            default: acc_reg <= i_output_bus;
                        endcase
                        o_rd_n <= 1'b1; // [R11]
                        cnt_reg <= SEL_LD[`CNT_W-1:0];
                        state_reg <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        if (last_part) begin
                            state_reg <= S_PUSH;
                        end else begin
                            part_reg <= part_reg + 1'b1;
                            if (mode_reg == `MODE_16) begin
                                o_width_select <= 1'b1; // [R5]
                            end else if (part_reg == 2'h0) begin
                                o_byte_select <= 1'b1; // [R7]
                            end else begin
                                o_width_select <= 1'b1; // [R6]
                            end
                            cnt_reg <= SEL_LD[`CNT_W-1:0];
                            state_reg <= S_SEL;
                        end
                    end
                end
                S_PUSH: begin
                    // full fifo drops the word and flags it
                    if (!fifo_ready) begin
                        overflow_reg <= 1'b1;
                    end
                    cnt_reg <= HOLD_LD[`CNT_W-1:0]; // [R8]
                    state_reg <= S_CSHOLD;
                end
                S_CSHOLD: begin
                    // chip select stays low well past status fall [R12]
                    if (cnt_reg == {`CNT_W{1'b0}}) begin
                        o_cs_n <= 1'b1;
                        o_width_select <= 1'b0;
                        o_byte_select <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ### logic/adc_ctrl_defines.vh
// constants for the parallel-readout converter controller
// assumes a 40 MHz system clock; included by adc_ctrl.v and adc_fifo.v
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// clock period in ns
`define CLK_PERIOD_NS 25
// read strobe low time, least, ns
`define T_RD_LOW_NS 50
`define RD_LOW_CYC ((`T_RD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read strobe high to next trigger fall, least, ns
`define T_RD_TO_TRIG_NS 50
`define RD_TO_TRIG_CYC \
    ((`T_RD_TO_TRIG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// select spacing, least, ns
`define T_SEL_SPACE_NS 50
`define SEL_SPACE_CYC \
    ((`T_SEL_SPACE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// chip select hold around status fall, least, ns
`define T_CS_BUSY_NS 50
`define CS_BUSY_CYC ((`T_CS_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// abort window after trigger fall, ns (least rounds up, most rounds down)
`define T_ABORT_MIN_NS 70
`define T_ABORT_MAX_NS 480
`define ABORT_MIN_CYC \
    ((`T_ABORT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ABORT_MAX_CYC (`T_ABORT_MAX_NS / `CLK_PERIOD_NS)
// acquisition time, least, ns
`define T_ACQ_NS 175
`define ACQ_CYC ((`T_ACQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// trigger low pulse, least, ns
`define T_TRIG_LOW_NS 40
`define TRIG_LOW_CYC ((`T_TRIG_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// register map of the controller (word index on the software port)
`define REG_CTRL 2'h0
`define REG_STAT 2'h1
`define REG_DATA 2'h2
// control bits
`define CTRL_START 0
`define CTRL_ABORT 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
// read width modes
`define MODE_18 2'h0
`define MODE_16 2'h1
`define MODE_8 2'h2
// widths
`define RES_W 18
`define CNT_W 5
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ### logic/adc_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_fifo #(
    parameter WIDTH = `RES_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW = `FIFO_AW
) (
    input wire i_clk, // system clock
    input wire i_nrst, // async reset, active low
    input wire i_in_valid, // write side data valid
    output wire o_in_ready, // write side may push
    input wire [WIDTH-1:0] i_in_data, // write data
    output wire o_out_valid, // read side data present
    input wire i_out_ready, // read side pops
    output wire [WIDTH-1:0] o_out_data // head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
    reg [AW-1:0] wr_ptr_reg; // write pointer
    reg [AW-1:0] rd_ptr_reg; // read pointer
    reg [AW:0] count_reg; // words held
    wire push;
    wire pop;

    assign o_in_ready = (count_reg != DEPTH[AW:0]);
    assign o_out_valid = (count_reg != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // storage is not reset; only pointers and count need defined values
    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // pointer and count bookkeeping
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ### tb/adc_ctrl_asserts.sv
// timing checks on the converter pins that the controller drives
// assumes it is bound into adc_ctrl; one clock, one reset
`timescale 1ns/1ps
module adc_ctrl_asserts (
    input wire i_clk, // system clock
    input wire i_nrst, // async reset, active low
    input wire o_cs_n, // chip select to converter
    input wire o_conversion_trigger_n, // trigger to converter
    input wire o_rd_n, // read strobe to converter
    input wire o_byte_select, // fold select
    input wire o_width_select, // width select
    input wire i_busy // converter status
);
    reg [7:0] since_trig_reg; // cycles since the last trigger fall
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////
    // saturating count, so a late abort edge cannot wrap into the window
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            since_trig_reg <= 8'hFF;
        end else if ($fell(o_conversion_trigger_n)) begin
            since_trig_reg <= 8'h01;
        end else if (since_trig_reg != 8'hFF) begin
            since_trig_reg <= since_trig_reg + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_read_to_trigger: assert property ($rose(o_rd_n) |->
        o_conversion_trigger_n [*2]) else $error("trigger too soon");
    a_read_when_idle: assert property (!o_rd_n |->
        !i_busy) else $error("read strobe while busy");
    a_cs_after_busy: assert property ($fell(i_busy) |->
        !o_cs_n [*2]) else $error("chip select up too soon");
    a_cs_before_busy: assert property ($rose(o_cs_n) |->
        !i_busy) else $error("chip select up while busy");
    a_byte_spacing: assert property ($changed(o_byte_select) |=>
        $stable(o_byte_select)) else $error("byte select too fast");
    a_width_spacing: assert property ($changed(o_width_select) |=>
        $stable(o_width_select)) else $error("width select too fast");
    a_abort_window: assert property (
        $fell(o_conversion_trigger_n) && i_busy |->
        since_trig_reg >= 8'h03 && since_trig_reg <= 8'h13)
        else $error("abort edge outside window");
endmodule

bind adc_ctrl adc_ctrl_asserts adc_ctrl_asserts_i (.i_clk(i_clk),
    .i_nrst(i_nrst), .o_cs_n(o_cs_n),
    .o_conversion_trigger_n(o_conversion_trigger_n), .o_rd_n(o_rd_n),
    .o_byte_select(o_byte_select), .o_width_select(o_width_select),
    .i_busy(i_busy));

// ### tb/adc_ctrl_tb.sv
// self-checking bench for the converter controller
// assumes adc_model on the pins and the bound checker beside it
`timescale 1ns/1ps
module adc_ctrl_tb;
    reg i_clk, i_nrst, i_wr, i_rd; // clock, reset, strobes
    reg [1:0] i_addr; // register index
    reg [7:0] i_wdata; // write data
    reg [17:0] next_res; // result the model delivers next
    reg [7:0] conv_cyc; // model conversion length
    reg [31:0] d; // last read data
    reg [3:0] idle; // state code seen after reset
    wire [31:0] o_rdata;
    wire cs_n, trig_n, rd_n, byte_sel, width_sel, busy;
    wire [17:0] bus;
    integer fails, checks_done, i;
    adc_ctrl adc_ctrl_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_cs_n(cs_n), .o_conversion_trigger_n(trig_n), .o_rd_n(rd_n),
        .o_byte_select(byte_sel), .o_width_select(width_sel),
        .i_busy(busy), .i_output_bus(bus));
    adc_model adc_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(cs_n),
        .i_conversion_trigger_n(trig_n), .i_rd_n(rd_n),
        .i_byte_select(byte_sel), .i_width_select(width_sel),
        .i_next_result(next_res), .i_conv_cycles(conv_cyc),
        .o_busy(busy), .o_output_bus(bus));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [8*9:1] what, input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    // one-cycle strobes, launched just after an edge
    task wr(input [1:0] a, input [7:0] v);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_wdata <= v;
            i_wr <= 1'b1;
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [1:0] a, output [31:0] v);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1 v = o_rdata;
        end
    endtask
    // poll status until masked bits match, bounded
    task wait_stat(input [7:0] m, input [7:0] v);
        integer n;
        begin
            n = 0;
            rd(2'h1, d);
            while ((d[7:0] & m) !== v && n < 400) begin
                rd(2'h1, d);
                n = n + 1;
            end
            if (n == 400) begin
                fails = fails + 1;
                final_report;
            end
        end
    endtask
    task convert(input [1:0] mode);
        begin
            wr(2'h0, {4'h0, mode, 2'h1});
            wait_stat(8'h0F, {4'h0, idle});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge i_clk);
        fails = fails + 1;
        final_report;
    end
    initial begin
        {i_nrst, i_wr, i_rd, i_addr, i_wdata} = 13'h0000;
        next_res = 18'h00000;
        conv_cyc = 8'h18;
        fails = 0;
        checks_done = 0;
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(2'h3, d);
        chk("unmapped", 32'h0, d);
        rd(2'h1, d);
        idle = d[3:0];
        chk("status", 32'h0, d & 32'hFFFFFFF0);
        // each read width, one result apiece
        for (i = 0; i < 3; i = i + 1) begin
            next_res = 18'h3A5C6 - i * 18'h1B2D9;
            convert(i[1:0]);
            rd(2'h2, d);
            chk("data", {1'b1, 13'h0, next_res}, d);
        end
        $display("test widths done");
        wr(2'h0, 8'h01);
        wr(2'h0, 8'h02);
        wait_stat(8'h20, 8'h20);
        chk("no push", 32'h0, d & 32'h80);
        wait_stat(8'h0F, {4'h0, idle});
        $display("test abort done");
        // nine results into eight places, slow and prompt in turn
        for (i = 0; i < 9; i = i + 1) begin
            next_res = 18'h01000 + i[17:0];
            conv_cyc = i[0] ? 8'h02 : 8'h18;
            convert(2'(i % 3));
        end
        rd(2'h1, d);
        chk("overflow", 32'hC0, d & 32'hC0);
        for (i = 0; i < 8; i = i + 1) begin
            rd(2'h2, d);
            chk("fifo word", {1'b1, 13'h0, 18'h01000 + i[17:0]}, d);
        end
        rd(2'h2, d);
        chk("empty", 32'h0, d & 32'h80000000);
        wr(2'h1, 8'h00);
        rd(2'h1, d);
        chk("ovf clear", 32'h0, d & 32'hC0);
        rd(2'h0, d);
        chk("ctrl", 32'h8, d); // last start was the 8-bit mode
        $display("test fifo done");
        final_report;
    end
endmodule

// ### tb/adc_model.sv
// behavioural model of the converter on the far side of the pins
// assumes pins synchronous to i_clk; the bench sets result and duration
`timescale 1ns/1ps
module adc_model (
    input wire i_clk, // system clock
    input wire i_nrst, // async reset, active low
    input wire i_cs_n, // chip select
    input wire i_conversion_trigger_n, // trigger
    input wire i_rd_n, // read strobe
    input wire i_byte_select, // fold select
    input wire i_width_select, // width select
    input wire [17:0] i_next_result, // result of the next conversion
    input wire [7:0] i_conv_cycles, // conversion length in cycles
    output reg o_busy, // status, high while converting
    output wire [17:0] o_output_bus // data bus
);
    reg [17:0] result_reg; // last finished result
    reg [17:0] last_reg; // last value driven, for the released bus
    reg [7:0] cnt_reg; // cycles left in the conversion
    reg trig_d_reg; // trigger one cycle ago
    reg cs_d_reg; // chip select one cycle ago
    reg [17:0] view; // bus pattern for the current selects
    wire trig_fall = trig_d_reg && !i_conversion_trigger_n && !i_cs_n;
    wire cs_fall = cs_d_reg && !i_cs_n; // opens acquisition
    ////////////////////////////////////////////////////////////////////////
    // unused pins read as ones, as the real part drives them
    always @* begin
        case ({i_width_select, i_byte_select})
            2'b00: view = result_reg;
            2'b10: view = {14'h3FFF, result_reg[1:0], 2'h3};
            2'b01: view = {result_reg[9:2], 10'h3FF};
            default: view = {6'h3F, result_reg[1:0], 10'h3FF};
        endcase
    end
    // released bus shows the inverse so stale data cannot pass
    assign o_output_bus = (!i_cs_n && !i_rd_n) ? view : ~last_reg;
    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer, abortable by a second edge
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_busy <= 1'b0;
            result_reg <= 18'h00000;
            last_reg <= 18'h00000;
            cnt_reg <= 8'h00;
            trig_d_reg <= 1'b1;
            cs_d_reg <= 1'b1;
        end else begin
            trig_d_reg <= i_conversion_trigger_n;
            cs_d_reg <= i_cs_n;
            if (!i_cs_n && !i_rd_n) begin
                last_reg <= view;
            end
            if (o_busy && (trig_fall || cs_fall)) begin
                o_busy <= 1'b0; // old result kept
            end else if (!o_busy && trig_fall) begin
                o_busy <= 1'b1;
                cnt_reg <= i_conv_cycles;
            end else if (o_busy && cnt_reg == 8'h00) begin
                o_busy <= 1'b0; // data valid as status falls
                result_reg <= i_next_result;
            end else if (o_busy) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule
